// ===== src/tmc_timer.sv
// Chainable down-counting timer with capture, compare and interrupts
`timescale 1ns/1ps
module tmc_timer #(
  parameter int unsigned NUM_BYTES = 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [tmc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [tmc_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [tmc_pkg::BE_W-1:0] avs_byteenable_i,
  output logic [tmc_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic src_clk_i,
  input wire logic cap_i,
  output logic tc_o,
  output logic cmp_o,
  output logic blk_irq_o,
  output logic irq_o
);
  import tmc_pkg::*;

  localparam int unsigned W = NUM_BYTES * BYTE_W;

  // Wider chains would not fit one bus word
  if (NUM_BYTES < 1 || NUM_BYTES > MAX_BYTES)
  begin : g_bad_width
    $error("tmc_timer: NUM_BYTES must be 1 to 4");
  end

  typedef struct packed {
    logic en;
    logic isrc;
    logic cmple;
    logic [W-1:0] period;
    logic [W-1:0] count;
    logic [W-1:0] capcmp;
    logic tc;
    logic cmp;
    logic blk;
    logic [STS_W-1:0] sts;
    logic [STS_W-1:0] ien;
    logic irq;
    logic wreq;
    logic [DATA_W-1:0] rdata;
  } tmc_state_s;

  tmc_state_s st_reg;
  tmc_state_s st_next;

  logic acc;
  logic rd;
  logic wr;
  logic [ADDR_W-3:0] word;
  logic sel_ctrl;
  logic sel_per;
  logic sel_cnt;
  logic sel_cap;
  logic sel_clr;
  logic sel_ien;
  logic src_rise;
  logic hw_rise;
  logic tick;
  logic zero;
  logic per_dis_wr;
  logic load;
  logic [W-1:0] per_new;
  logic [W-1:0] load_val;
  logic [W-1:0] cnt_nx;
  logic [NUM_BYTES:0] borrow;
  logic sw_cap;
  logic hw_cap;
  logic cap_ev;

  // Keeps unselected byte lanes of a register
  function automatic logic [W-1:0] be_merge(
    input logic [W-1:0] old,
    input logic [DATA_W-1:0] wd,
    input logic [BE_W-1:0] be
  );
    logic [DATA_W-1:0] r;
    r = DATA_W'(old);
    for (int i = 0; i < BE_W; i++)
    begin
      if (be[i])
        r[BYTE_W*i +: BYTE_W] = wd[BYTE_W*i +: BYTE_W];
    end
    return r[W-1:0];
  endfunction

  // Source clock and capture both pass a synchroniser
  tmc_edge u_src_edge (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(src_clk_i),
    .rise_o(src_rise)
  );

  tmc_edge u_cap_edge (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(cap_i),
    .rise_o(hw_rise) // (R6)
  );

  // Bus access accepted once, while waitrequest is high
  assign acc = (avs_read_i | avs_write_i) & st_reg.wreq;
  assign rd = acc & avs_read_i;
  assign wr = acc & avs_write_i;
  assign word = avs_address_i[ADDR_W-1:2];
  assign sel_ctrl = (word == OFF_CTRL[ADDR_W-1:2]);
  assign sel_per = (word == OFF_PERIOD[ADDR_W-1:2]);
  assign sel_cnt = (word == OFF_COUNT[ADDR_W-1:2]);
  assign sel_cap = (word == OFF_CAPCMP[ADDR_W-1:2]);
  assign sel_clr = (word == OFF_IRQ_CLR[ADDR_W-1:2]);
  assign sel_ien = (word == OFF_IRQ_EN[ADDR_W-1:2]);

  // Counter stepping; block clock stopped while disabled
  assign tick = st_reg.en & src_rise; // (R16)
  assign zero = (st_reg.count == '0);
  assign per_new = be_merge(st_reg.period, avs_writedata_i, avs_byteenable_i);
  assign per_dis_wr = wr & sel_per & ~st_reg.en; // (R1)
  assign load = per_dis_wr | (tick & zero); // (R2)
  assign load_val = per_dis_wr ? per_new : st_reg.period;
  assign borrow[0] = tick & ~zero; // (R5)

  // One slice per byte of the chain
  for (genvar b = 0; b < NUM_BYTES; b++)
  begin : g_slice
    tmc_slice u_slice (
      .cur_i(st_reg.count[BYTE_W*b +: BYTE_W]),
      .load_val_i(load_val[BYTE_W*b +: BYTE_W]),
      .load_i(load),
      .borrow_i(borrow[b]),
      .nxt_o(cnt_nx[BYTE_W*b +: BYTE_W]),
      .borrow_o(borrow[b+1])
    );
  end

  // Only the low count byte triggers; whole count moves at once
  assign sw_cap = rd & sel_cnt & avs_byteenable_i[0]; // (R4) (R12)
  assign hw_cap = hw_rise & st_reg.en;
  assign cap_ev = sw_cap | hw_cap; // (R7)

  // Next state of the whole block
  always_comb
  begin
    st_next = st_reg;
    st_next.wreq = ~acc;
    // Control bits
    if (wr && sel_ctrl && avs_byteenable_i[0])
    begin
      st_next.en = avs_writedata_i[CTRL_EN_BIT]; // (R14)
      st_next.isrc = avs_writedata_i[CTRL_ISRC_BIT];
      st_next.cmple = avs_writedata_i[CTRL_CMPLE_BIT];
    end
    if (wr && sel_per)
      st_next.period = per_new;
    st_next.count = cnt_nx;
    // Capture wins over a CPU compare write in the same cycle
    if (cap_ev)
      st_next.capcmp = st_reg.count; // (R3) (R17)
    else if (wr && sel_cap)
      st_next.capcmp = be_merge(st_reg.capcmp, avs_writedata_i, avs_byteenable_i);
    // Outputs from next values so they stay flop-driven
    st_next.tc = st_next.en & (cnt_nx == '0); // (R8)
    if (st_next.cmple)
      st_next.cmp = st_next.en & (cnt_nx <= st_next.capcmp); // (R9)
    else
      st_next.cmp = st_next.en & (cnt_nx < st_next.capcmp); // (R9)
    if (st_next.isrc)
      st_next.blk = st_next.cmp & ~st_reg.cmp; // (R10)
    else
      st_next.blk = st_next.tc & ~st_reg.tc; // (R10)
    // Sticky status: a new event beats a clear
    if (wr && sel_clr && avs_byteenable_i[0])
      st_next.sts = st_reg.sts & ~avs_writedata_i[STS_W-1:0];
    st_next.sts[STS_TC_BIT] = st_next.sts[STS_TC_BIT] | (st_next.tc & ~st_reg.tc);
    st_next.sts[STS_CMP_BIT] = st_next.sts[STS_CMP_BIT] | (st_next.cmp & ~st_reg.cmp);
    st_next.sts[STS_CAP_BIT] = st_next.sts[STS_CAP_BIT] | cap_ev;
    if (wr && sel_ien && avs_byteenable_i[0])
      st_next.ien = avs_writedata_i[STS_W-1:0];
    st_next.irq = |(st_next.sts & st_next.ien);
    // Read data; count word reads as zero, unmapped as zero
    st_next.rdata = '0;
    if (rd)
    begin
      case (word)
        OFF_CTRL[ADDR_W-1:2]:
        begin
          st_next.rdata[CTRL_EN_BIT] = st_reg.en;
          st_next.rdata[CTRL_ISRC_BIT] = st_reg.isrc;
          st_next.rdata[CTRL_CMPLE_BIT] = st_reg.cmple;
        end
        OFF_PERIOD[ADDR_W-1:2]:
          st_next.rdata = DATA_W'(st_reg.period);
        OFF_CAPCMP[ADDR_W-1:2]:
          st_next.rdata = DATA_W'(st_reg.capcmp);
        OFF_IRQ_STS[ADDR_W-1:2]:
          st_next.rdata = DATA_W'(st_reg.sts);
        OFF_IRQ_EN[ADDR_W-1:2]:
          st_next.rdata = DATA_W'(st_reg.ien);
        OFF_STATE[ADDR_W-1:2]:
        begin
          st_next.rdata[ST_TC_BIT] = st_reg.tc;
          st_next.rdata[ST_CMP_BIT] = st_reg.cmp;
        end
        default:
          st_next.rdata = '0; // (R4)
      endcase
    end
  end

  // State register; everything clears except waitrequest, which resets high, timer left disabled
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_reg <= '0;
      st_reg.en <= CTRL_RST; // (R18)
      st_reg.period <= DATA_RST[W-1:0];
      st_reg.count <= DATA_RST[W-1:0];
      st_reg.capcmp <= DATA_RST[W-1:0];
      st_reg.sts <= STS_RST;
      st_reg.ien <= STS_RST;
      st_reg.wreq <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign avs_readdata_o = st_reg.rdata;
  assign avs_waitrequest_o = st_reg.wreq;
  assign tc_o = st_reg.tc;
  assign cmp_o = st_reg.cmp;
  assign blk_irq_o = st_reg.blk;
  assign irq_o = st_reg.irq;

  // Checks on the block's own behaviour
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_per_load;
    per_dis_wr && (avs_byteenable_i == 4'hF) |=> st_reg.count == $past(avs_writedata_i[W-1:0]);
  endproperty
  a_per_load: assert property (p_per_load) else $error("period write did not load count"); // (R1)

  property p_reload;
    tick && zero |=> st_reg.count == $past(st_reg.period);
  endproperty
  a_reload: assert property (p_reload) else $error("zero count not reloaded"); // (R2)

  property p_capture;
    cap_ev |=> st_reg.capcmp == $past(st_reg.count);
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost the count"); // (R3)

  property p_cnt_read;
    rd && sel_cnt |=> !avs_waitrequest_o && avs_readdata_o == 32'h0 ##1 avs_waitrequest_o;
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count read not zero"); // (R4)

  property p_dec;
    tick && !zero |=> st_reg.count == $past(st_reg.count) - W'(1);
  endproperty
  a_dec: assert property (p_dec) else $error("counter did not decrement"); // (R5)

  property p_hold;
    !tick && !per_dis_wr |=> st_reg.count == $past(st_reg.count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without a tick"); // (R16)

  property p_hw_cap;
    $rose(cap_i) |-> ##2 hw_rise;
  endproperty
  a_hw_cap: assert property (p_hw_cap) else $error("capture edge not synchronised"); // (R6)

  property p_tc;
    tc_o == (st_reg.en && st_reg.count == '0);
  endproperty
  a_tc: assert property (p_tc) else $error("terminal count mismatch"); // (R8)

  property p_cmp;
    cmp_o == (st_reg.en && (st_reg.cmple ? st_reg.count <= st_reg.capcmp : st_reg.count < st_reg.capcmp));
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare output mismatch"); // (R9)

  property p_blk;
    blk_irq_o == (st_reg.isrc ? $rose(cmp_o) : $rose(tc_o));
  endproperty
  a_blk: assert property (p_blk) else $error("block interrupt edge mismatch"); // (R10)

  property p_dis;
    !st_reg.en |-> !tc_o && !cmp_o && !blk_irq_o;
  endproperty
  a_dis: assert property (p_dis) else $error("outputs active while disabled"); // (R16)

  property p_en_wr;
    wr && sel_ctrl && avs_byteenable_i[0] |=> st_reg.en == $past(avs_writedata_i[CTRL_EN_BIT]);
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable bit not written"); // (R14)

  // Status bits follow the events; set wins over a same-cycle clear
  property p_tc_sts;
    $rose(tc_o) |-> st_reg.sts[STS_TC_BIT];
  endproperty
  a_tc_sts: assert property (p_tc_sts) else $error("tc rise not latched"); // (R10)

  property p_cmp_sts;
    $rose(cmp_o) |-> st_reg.sts[STS_CMP_BIT];
  endproperty
  a_cmp_sts: assert property (p_cmp_sts) else $error("compare rise not latched"); // (R10)

  property p_cap_sts;
    cap_ev |=> st_reg.sts[STS_CAP_BIT];
  endproperty
  a_cap_sts: assert property (p_cap_sts) else $error("capture not latched"); // (R3)

  // Hardware capture is ignored while the timer is off
  property p_hw_dis;
    hw_rise && !st_reg.en && !sw_cap && !(wr && sel_cap) |=> st_reg.capcmp == $past(st_reg.capcmp);
  endproperty
  a_hw_dis: assert property (p_hw_dis) else $error("capture while disabled"); // (R16)

  // A count read without lane 0 is no software capture
  property p_cap_lane;
    rd && sel_cnt && !avs_byteenable_i[0] && !hw_cap |=> st_reg.capcmp == $past(st_reg.capcmp);
  endproperty
  a_cap_lane: assert property (p_cap_lane) else $error("capture without low byte"); // (R12)

  // One answer cycle per access, then back to idle
  property p_wait;
    acc |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest not a one-cycle answer");

  // Read data stand only in the answer cycle
  property p_rd_idle;
    !rd |=> avs_readdata_o == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");

  c_sw_cap: cover property (sw_cap ##[1:8] rd && sel_cap);
  c_hw_cap: cover property (hw_cap);
  c_tc_irq: cover property (blk_irq_o && irq_o);
  c_reload: cover property (tick && zero);
  c_cmp_irq: cover property (st_reg.isrc && blk_irq_o);
endmodule

// ===== src/tmc_pkg.sv
// Package: register map, field positions and reset values of the capture timer
// Operation
// (R1) Period write while disabled loads counter
// (R2) Zero count reloads period on next tick
// (R3) Capture copies count into capture/compare
// (R4) Count read captures and returns zero
// (R5) Counter decrements on source clock rise
// (R6) Hardware capture rise synchronised, then transferred
// (R7) Hardware capture ORed with software capture
// (R8) Terminal count high while count is zero
// (R9) Compare true: less, or less-or-equal
// (R10) Interrupt on rise of selected source
// (R11) Capture only with source at 24 MHz
// (R12) Chained capture moves all bytes together
// (R13) Counter width chains in 8-bit steps
// (R14) One enable bit switches timer on
// (R15) Compare value may offset periodic interrupt
// (R16) Disabled: clock stopped, outputs low, count kept
// (R17) Capture overwrites the compare value
// (R18) Reset clears data registers and enable
package tmc_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned BE_W = 4;
  // Byte offsets of the register words
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_CAPCMP = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STS = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_STATE = 5'h1C;
  // Control word fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_ISRC_BIT = 1;
  localparam int unsigned CTRL_CMPLE_BIT = 2;
  // Interrupt status, clear and enable fields
  localparam int unsigned STS_W = 3;
  localparam int unsigned STS_TC_BIT = 0;
  localparam int unsigned STS_CMP_BIT = 1;
  localparam int unsigned STS_CAP_BIT = 2;
  // State word fields
  localparam int unsigned ST_TC_BIT = 0;
  localparam int unsigned ST_CMP_BIT = 1;
  // Reset values
  localparam logic CTRL_RST = 1'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0;
  localparam logic [STS_W-1:0] STS_RST = 3'h0;
  // Counter geometry
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned MAX_BYTES = 4;
endpackage

// ===== src/tmc_edge.sv
// Two-flop synchroniser followed by a rising edge detector
`timescale 1ns/1ps
module tmc_edge (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic d_i,
  output logic rise_o
);
  import tmc_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic q;
  } tmc_edge_s;

  tmc_edge_s st_reg;
  tmc_edge_s st_next;

  // First stage feeds only the second stage
  always_comb
  begin
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
    st_next.q = st_reg.s2;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Edge taken between the settled stages
  assign rise_o = st_reg.s2 & ~st_reg.q;
endmodule

// ===== src/tmc_slice.sv
// One byte of the chained down counter, next value and borrow
`timescale 1ns/1ps
module tmc_slice (
  input wire logic [tmc_pkg::BYTE_W-1:0] cur_i,
  input wire logic [tmc_pkg::BYTE_W-1:0] load_val_i,
  input wire logic load_i,
  input wire logic borrow_i,
  output logic [tmc_pkg::BYTE_W-1:0] nxt_o,
  output logic borrow_o
);
  import tmc_pkg::*;

  // Load beats decrement; borrow ripples through empty bytes
  always_comb
  begin
    if (load_i)
      nxt_o = load_val_i;
    else if (borrow_i)
      nxt_o = cur_i - 8'h01; // (R5)
    else
      nxt_o = cur_i;
    borrow_o = borrow_i & (cur_i == 8'h00); // (R13)
  end
endmodule

// ===== testbench/tmc_src_model.sv
// Far-side model: routed source clock and hardware capture line
`timescale 1ns/1ps
module tmc_src_model #(
  parameter int unsigned HALF = 3
) (
  input wire logic clk_i,
  output logic src_clk_o,
  output logic cap_o
);
  // Both lines idle low; the source clock stands still between bursts
  initial
  begin
    src_clk_o = 1'b0;
    cap_o = 1'b0;
  end

  // Burst of n source periods, 2*HALF system cycles each, so at most 24 MHz
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      src_clk_o <= 1'b1;
      repeat (HALF) @(posedge clk_i);
      src_clk_o <= 1'b0;
      repeat (HALF - 1) @(posedge clk_i);
    end
  endtask

  // One capture pulse, long enough for the two-flop synchroniser
  task automatic capture();
    @(posedge clk_i);
    cap_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    cap_o <= 1'b0;
  endtask
endmodule

// ===== testbench/timer_with_capture_tb.sv
// Self-checking bench for the capture timer over its register bus
`timescale 1ns/1ps
module timer_with_capture_tb;
  import tmc_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic rd_r = 1'b0;
  logic wr_r = 1'b0;
  logic [DATA_W-1:0] wdat = '0;
  logic [BE_W-1:0] be = 4'hF;
  logic [DATA_W-1:0] rdat;
  logic [DATA_W-1:0] rdata;
  logic wait_req;
  logic src_clk;
  logic cap;
  logic tc;
  logic cmp;
  logic blk_irq;
  logic irq;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int blk_count = 0;

  // Two bytes chained, so borrow and whole-count capture are exercised
  tmc_timer #(.NUM_BYTES(2)) i_tmc_timer (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd_r),
    .avs_write_i(wr_r), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .src_clk_i(src_clk),
    .cap_i(cap), .tc_o(tc), .cmp_o(cmp), .blk_irq_o(blk_irq), .irq_o(irq)
  );

  tmc_src_model #(.HALF(3)) i_tmc_src_model (
    .clk_i(clk_i), .src_clk_o(src_clk), .cap_o(cap)
  );

  // 100 MHz system clock
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard, well above the length of the sequence
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      end_sim();
    end
  end

  // Counts block interrupt pulses; each is one cycle wide
  always @(posedge clk_i)
  begin
    if (blk_irq === 1'b1)
      blk_count <= blk_count + 1;
  end

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t %s got %0h want %0h", $time, what, got, exp);
    end
  endtask

  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    @(posedge clk_i);
    adr <= a;
    wdat <= wd;
    wr_r <= wr;
    rd_r <= ~wr;
    do @(posedge clk_i); while (wait_req !== 1'b0);
    rdat = rdata;
    wr_r <= 1'b0;
    rd_r <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    bus(1'b1, a, wd);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] m);
    bus(1'b0, a, '0);
    chk(rdat & m, exp, "register read");
  endtask

  // Software capture, then the captured count
  task automatic cap_chk(input logic [DATA_W-1:0] exp);
    rd_chk(OFF_COUNT, 32'h0, 32'hFFFFFFFF);
    rd_chk(OFF_CAPCMP, exp, 32'hFFFFFFFF);
  endtask

  // Lets synchroniser and registered outputs settle
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask

  task automatic pins(input logic [3:0] exp);
    chk({28'h0, tc, cmp, blk_irq, irq}, {28'h0, exp}, "output pins");
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    // Reset state
    rd_chk(OFF_CTRL, 32'h0, 32'hFFFFFFFF);
    rd_chk(OFF_PERIOD, 32'h0, 32'hFFFFFFFF);
    rd_chk(OFF_CAPCMP, 32'h0, 32'hFFFFFFFF);
    rd_chk(OFF_IRQ_STS, 32'h0, 32'hFFFFFFFF);
    pins(4'h0);
    // Disabled period write loads the counter; count read captures
    wr(OFF_PERIOD, 32'h0000_0100);
    cap_chk(32'h0000_0100);
    // Borrow across the byte boundary; a read without lane 0 must not capture
    wr(OFF_CTRL, 32'h1);
    i_tmc_src_model.ticks(1);
    settle();
    be <= 4'h2;
    rd_chk(OFF_COUNT, 32'h0, 32'hFFFFFFFF);
    be <= 4'hF;
    rd_chk(OFF_CAPCMP, 32'h0000_0100, 32'hFFFFFFFF);
    // Low count byte alone moves the whole count
    be <= 4'h1;
    rd_chk(OFF_COUNT, 32'h0, 32'hFFFFFFFF);
    be <= 4'hF;
    rd_chk(OFF_CAPCMP, 32'h0000_00FF, 32'hFFFFFFFF);
    // Terminal count after period ticks, with interrupt
    wr(OFF_CTRL, 32'h0);
    wr(OFF_PERIOD, 32'h3);
    wr(OFF_IRQ_CLR, 32'h7);
    wr(OFF_IRQ_EN, 32'h1);
    wr(OFF_CTRL, 32'h1);
    i_tmc_src_model.ticks(2);
    settle();
    chk({31'h0, tc}, 32'h0, "tc early");
    i_tmc_src_model.ticks(1);
    settle();
    chk({31'h0, tc}, 32'h1, "tc at zero");
    chk(blk_count, 32'h1, "block irq on tc");
    rd_chk(OFF_STATE, 32'h1, 32'h1);
    rd_chk(OFF_IRQ_STS, 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(OFF_IRQ_CLR, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // Zero reloads the period on the next tick
    i_tmc_src_model.ticks(2);
    settle();
    cap_chk(32'h2);
    chk({31'h0, tc}, 32'h0, "tc after reload");
    // Compare: count equals value, less-than false, less-or-equal true
    wr(OFF_CTRL, 32'h3);
    settle();
    chk({31'h0, cmp}, 32'h0, "cmp lt");
    wr(OFF_CTRL, 32'h7);
    settle();
    chk({31'h0, cmp}, 32'h1, "cmp le");
    chk(blk_count, 32'h2, "block irq on cmp");
    rd_chk(OFF_STATE, 32'h2, 32'h2);
    // Hardware capture overwrites the compare value
    wr(OFF_IRQ_CLR, 32'h4);
    i_tmc_src_model.ticks(1);
    i_tmc_src_model.capture();
    settle();
    rd_chk(OFF_CAPCMP, 32'h1, 32'hFFFFFFFF);
    rd_chk(OFF_IRQ_STS, 32'h4, 32'h4);
    // Capture status interrupt, masked and unmasked
    wr(OFF_IRQ_EN, 32'h4);
    settle();
    chk({31'h0, irq}, 32'h1, "capture irq");
    wr(OFF_IRQ_EN, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0, "irq masked");
    rd_chk(OFF_IRQ_EN, 32'h0, 32'h7);
    // Disabled: outputs low, ticks and hardware capture ignored, count kept
    wr(OFF_CTRL, 32'h0);
    settle();
    pins(4'h0);
    wr(OFF_CAPCMP, 32'h0000_0055);
    i_tmc_src_model.ticks(2);
    i_tmc_src_model.capture();
    settle();
    rd_chk(OFF_CAPCMP, 32'h0000_0055, 32'hFFFFFFFF);
    cap_chk(32'h1);
    wr(OFF_IRQ_CLR, 32'h7);
    rd_chk(OFF_IRQ_STS, 32'h0, 32'h7);
    // Reset in mid-run clears everything again
    wr(OFF_IRQ_EN, 32'h7);
    wr(OFF_CTRL, 32'h1);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    pins(4'h0);
    rd_chk(OFF_CTRL, 32'h0, 32'hFFFFFFFF);
    rd_chk(OFF_PERIOD, 32'h0, 32'hFFFFFFFF);
    rd_chk(OFF_IRQ_EN, 32'h0, 32'hFFFFFFFF);
    cap_chk(32'h0);
    end_sim();
  end
endmodule
